// ---- testbench/display_pll_divisor_and_ref_clock_ctl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pll_ref_defines.svh"

module display_pll_divisor_and_ref_clock_ctl_tb
  import pll_ref_pkg::*;
;
  logic clk, reset, reg_write, reg_read, vblank, panel_connected, alternate_in_use;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_rvalid, write_blocked, pll_oscillator_on, display_clock_run, post_div_reserved;
  logic [3:0] post_div_ratio;
  logic [5:0] n_div, m_coarse_div, m_fine_div;
  logic [2:0] vco_band_tune, long_mix_repeats;
  logic doubler_clock_on, spread_source_on, flat_source_internal, flat_source_external;
  logic wide_spread_source_on, cpu_ref_spread_out, cpu_ref_flat_out, half_pct_modulator_on;
  logic variable_modulator_on, variable_modulator_spread_type, modulated_ref_stable, timer_tick;
  int fails = 0;
  int comparisons = 0;
  int ticks;
  logic [19:0] addrs [6] = '{`ADDR_PLL_CONTROL, `ADDR_DIV_SET0, `ADDR_DIV_SET1,
    `ADDR_RAW_FREQ, `ADDR_MOD_PARAMS, `ADDR_REF_CONTROL};
  logic [31:0] rsts [6] = '{`RST_PLL_CONTROL, `RST_DIV_SET0, `RST_DIV_SET1,
    `RST_RAW_FREQ, `RST_MOD_PARAMS, `RST_REF_CONTROL};
  logic [31:0] masks [6] = '{`MASK_PLL_CONTROL, `MASK_DIV_SET0, `MASK_DIV_SET1,
    `MASK_RAW_FREQ, `MASK_MOD_PARAMS, `MASK_REF_CONTROL};

  display_pll_divisor_and_ref_clock_ctl i_display_pll_divisor_and_ref_clock_ctl (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .vblank(vblank),
    .panel_connected(panel_connected), .alternate_in_use(alternate_in_use),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .write_blocked(write_blocked),
    .pll_oscillator_on(pll_oscillator_on), .display_clock_run(display_clock_run),
    .post_div_ratio(post_div_ratio), .post_div_reserved(post_div_reserved),
    .n_div(n_div), .m_coarse_div(m_coarse_div), .m_fine_div(m_fine_div),
    .vco_band_tune(vco_band_tune), .doubler_clock_on(doubler_clock_on),
    .spread_source_on(spread_source_on), .flat_source_internal(flat_source_internal),
    .flat_source_external(flat_source_external),
    .wide_spread_source_on(wide_spread_source_on), .cpu_ref_spread_out(cpu_ref_spread_out),
    .cpu_ref_flat_out(cpu_ref_flat_out), .half_pct_modulator_on(half_pct_modulator_on),
    .variable_modulator_on(variable_modulator_on),
    .variable_modulator_spread_type(variable_modulator_spread_type),
    .modulated_ref_stable(modulated_ref_stable), .long_mix_repeats(long_mix_repeats),
    .timer_tick(timer_tick)
  );

  // ***************************************************
  // Clock, helpers
  // ***************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Inputs change on the falling edge, so the rising edge always sees them settled
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    // Read data stand for one cycle only, so look before the next edge
    chk(32'(reg_rvalid), 32'h1, "read valid");
    chk(reg_rdata, exp, "read data");
  endtask

  task automatic div_chk(input logic [5:0] n, input logic [5:0] mc, input logic [5:0] mf);
    chk(32'(n_div), 32'(n), "n divisor");
    chk(32'(m_coarse_div), 32'(mc), "m coarse divisor");
    chk(32'(m_fine_div), 32'(mf), "m fine divisor");
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, fails);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run needs well under 3000 cycles; the margin absorbs slow waits
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  // ***************************************************
  // Tests
  // ***************************************************
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 20'h00000;
    reg_wdata = 32'h00000000;
    vblank = 1'b0;
    panel_connected = 1'b0;
    alternate_in_use = 1'b0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    wt(1);
    chk(32'(post_div_ratio), 32'h8, "reset post divider");
    chk(32'(long_mix_repeats), 32'h1, "reset long mix");
    div_chk(6'h03, 6'h0D, 6'h07);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], rsts[i]);
    end_test("reset values");

    for (int i = 0; i < 6; i++) begin
      wr(addrs[i], 32'hFFFFFFFF);
      rd_chk(addrs[i], masks[i]);
    end
    // Reverse order turns the modulators off before their parameters change
    for (int i = 5; i >= 0; i--) begin
      wr(addrs[i], 32'h00000000);
      rd_chk(addrs[i], 32'h00000000);
    end
    wr(20'hC6100, 32'hFFFFFFFF);
    rd_chk(20'hC6100, 32'h00000000);
    end_test("reserved bits");

    // Oscillator on, so only immediacy can explain the ratio change
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_PLL_CONTROL, 32'h80000000 | (32'h1 << k));
      wt(2);
      chk(32'(post_div_ratio), 32'(k + 1), "post divider ratio");
      chk(32'(post_div_reserved), 32'h0, "post divider legal");
    end
    wr(`ADDR_PLL_CONTROL, 32'h80000003);
    wt(2);
    chk(32'(post_div_ratio), 32'h0, "reserved ratio");
    chk(32'(post_div_reserved), 32'h1, "reserved flag");
    end_test("post divider");

    wr(`ADDR_PLL_CONTROL, 32'h00000080);
    wt(2);
    chk(32'(pll_oscillator_on), 32'h0, "oscillator off");
    chk(32'(display_clock_run), 32'h0, "clock stopped");
    wr(`ADDR_DIV_SET0, 32'h08C51208);
    wr(`ADDR_DIV_SET1, 32'h00C70A05);
    wr(`ADDR_PLL_CONTROL, 32'h80000080);
    wt(2);
    div_chk(6'h05, 6'h12, 6'h08);
    chk(32'(vco_band_tune), 32'h3, "band tune");
    chk(32'(doubler_clock_on), 32'h1, "doubler on");
    chk(32'(display_clock_run), 32'h1, "clock running");
    alternate_in_use = 1'b1;
    wt(2);
    div_chk(6'h07, 6'h0A, 6'h05);
    chk(32'(vco_band_tune), 32'h3, "alternate band tune");
    chk(32'(doubler_clock_on), 32'h1, "doubler from primary");
    wr(`ADDR_DIV_SET1, 32'h00C60B06);
    alternate_in_use = 1'b0;
    wr(`ADDR_DIV_SET0, 32'h00C40B06);
    rd_chk(`ADDR_DIV_SET0, 32'h00C40B06);
    div_chk(6'h05, 6'h12, 6'h08);
    @(negedge clk);
    vblank = 1'b1;
    @(negedge clk);
    vblank = 1'b0;
    wt(2);
    div_chk(6'h04, 6'h0B, 6'h06);
    chk(32'(doubler_clock_on), 32'h0, "doubler off");
    alternate_in_use = 1'b1;
    wt(2);
    div_chk(6'h06, 6'h0B, 6'h06);
    alternate_in_use = 1'b0;
    panel_connected = 1'b1;
    wr(`ADDR_DIV_SET0, 32'h00050C07);
    chk(32'(write_blocked), 32'h1, "write refused");
    wt(1);
    chk(32'(write_blocked), 32'h0, "refusal pulse");
    rd_chk(`ADDR_DIV_SET0, 32'h00C40B06);
    panel_connected = 1'b0;
    wr(`ADDR_PLL_CONTROL, 32'h00000080);
    wt(2);
    chk(32'(pll_oscillator_on), 32'h0, "oscillator off again");
    end_test("divisor sets");

    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_REF_CONTROL, (32'(c) << 11) | (32'(c) << 9) | (32'(c) << 7));
      wt(2);
      chk(32'(spread_source_on), 32'(c == 2), "spread source");
      chk(32'(flat_source_internal), 32'(c == 2), "flat internal");
      chk(32'(flat_source_external), 32'(c == 1), "flat external");
      chk(32'(wide_spread_source_on), 32'(c == 2), "wide source");
    end
    wr(`ADDR_REF_CONTROL, 32'h00005002);
    wt(2);
    chk(32'(cpu_ref_spread_out), 32'h1, "cpu spread out");
    chk(32'(half_pct_modulator_on), 32'h1, "half modulator");
    wr(`ADDR_REF_CONTROL, 32'h00006200);
    wt(2);
    chk(32'(cpu_ref_flat_out), 32'h1, "cpu flat out");
    wr(`ADDR_REF_CONTROL, 32'h00003202);
    wt(2);
    chk(32'(cpu_ref_spread_out | cpu_ref_flat_out), 32'h0, "cpu reserved");
    end_test("reference sources");

    // Modulator off first so the settle count starts from this write
    wr(`ADDR_REF_CONTROL, 32'h00000000);
    wr(`ADDR_REF_CONTROL, 32'h00000141);
    wt(45);
    chk(32'(modulated_ref_stable), 32'h0, "not yet stable");
    chk(32'(variable_modulator_on), 32'h1, "variable modulator");
    chk(32'(variable_modulator_spread_type), 32'h1, "center spread");
    wt(10);
    chk(32'(modulated_ref_stable), 32'h1, "stable");
    wr(`ADDR_REF_CONTROL, 32'h00000100);
    wt(3);
    chk(32'(modulated_ref_stable), 32'h0, "stable dropped");
    chk(32'(variable_modulator_on), 32'h0, "zero spread");
    chk(32'(wide_spread_source_on), 32'h1, "source kept");
    end_test("modulator settle");

    wr(`ADDR_RAW_FREQ, 32'h00000005);
    wt(4);
    ticks = 0;
    repeat (50) begin
      @(negedge clk);
      if (timer_tick === 1'b1) ticks++;
    end
    chk(32'(ticks), 32'd10, "timer ticks");
    wr(`ADDR_RAW_FREQ, 32'h00000000);
    wt(2);
    ticks = 0;
    repeat (20) begin
      @(negedge clk);
      if (timer_tick === 1'b1) ticks++;
    end
    chk(32'(ticks), 32'd0, "no ticks");
    wr(`ADDR_MOD_PARAMS, 32'h3000A4A8);
    wt(2);
    chk(32'(long_mix_repeats), 32'h4, "long mix count");
    rd_chk(`ADDR_MOD_PARAMS, 32'h3000A4A8);
    wr(`ADDR_MOD_PARAMS, 32'h1270A428);
    wt(2);
    chk(32'(long_mix_repeats), 32'h2, "recommended long mix");
    rd_chk(`ADDR_MOD_PARAMS, 32'h1270A428);
    end_test("timer and params");
    stop_test();
  end

endmodule // display_pll_divisor_and_ref_clock_ctl_tb
`default_nettype wire

// ---- verilog/display_pll_divisor_and_ref_clock_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pll_ref_defines.svh"

module display_pll_divisor_and_ref_clock_ctl
  import pll_ref_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [19:0] reg_addr,
  input wire logic reg_write,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_read,
  input wire logic vblank,
  input wire logic panel_connected,
  input wire logic alternate_in_use,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic write_blocked,
  output logic pll_oscillator_on,
  output logic display_clock_run,
  output logic [3:0] post_div_ratio,
  output logic post_div_reserved,
  output logic [5:0] n_div,
  output logic [5:0] m_coarse_div,
  output logic [5:0] m_fine_div,
  output logic [2:0] vco_band_tune,
  output logic doubler_clock_on,
  output logic spread_source_on,
  output logic flat_source_internal,
  output logic flat_source_external,
  output logic wide_spread_source_on,
  output logic cpu_ref_spread_out,
  output logic cpu_ref_flat_out,
  output logic half_pct_modulator_on,
  output logic variable_modulator_on,
  output logic variable_modulator_spread_type,
  output logic modulated_ref_stable,
  output logic [2:0] long_mix_repeats,
  output logic timer_tick
);

  // ***************************************************
  // Register port decode
  // ***************************************************
  logic hit_ctl;
  logic hit_set0;
  logic hit_set1;
  logic hit_ref;
  logic hit_raw;
  logic hit_mod;
  logic set_write;

  assign hit_ctl = reg_addr == `ADDR_PLL_CONTROL;
  assign hit_set0 = reg_addr == `ADDR_DIV_SET0;
  assign hit_set1 = reg_addr == `ADDR_DIV_SET1;
  assign hit_ref = reg_addr == `ADDR_REF_CONTROL;
  assign hit_raw = reg_addr == `ADDR_RAW_FREQ;
  assign hit_mod = reg_addr == `ADDR_MOD_PARAMS;
  assign set_write = reg_write && (hit_set0 || hit_set1);

  // ***************************************************
  // Plain registers
  // ***************************************************
  logic [31:0] ctl_q, ctl_d;
  logic [31:0] ref_q, ref_d;
  logic [31:0] raw_q, raw_d;
  logic [31:0] mod_q, mod_d;
  logic post_write;

  assign post_write = reg_write && hit_ctl;

  always_comb begin
    ctl_d = ctl_q;
    ref_d = ref_q;
    raw_d = raw_q;
    mod_d = mod_q;
    // Masks keep reserved bits at zero whatever is written
    if (post_write) begin
      ctl_d = reg_wdata & `MASK_PLL_CONTROL;
    end
    if (reg_write && hit_ref) begin
      ref_d = reg_wdata & `MASK_REF_CONTROL;
    end
    if (reg_write && hit_raw) begin
      raw_d = reg_wdata & `MASK_RAW_FREQ;
    end
    if (reg_write && hit_mod) begin
      mod_d = reg_wdata & `MASK_MOD_PARAMS;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q <= `RST_PLL_CONTROL;
      ref_q <= `RST_REF_CONTROL;
      raw_q <= `RST_RAW_FREQ;
      mod_q <= `RST_MOD_PARAMS;
    end else begin
      ctl_q <= ctl_d;
      ref_q <= ref_d;
      raw_q <= raw_d;
      mod_q <= mod_d;
    end
  end

  // ***************************************************
  // Divisor sets
  // ***************************************************
  logic [31:0] set0_written, set0_active;
  logic [31:0] set1_written, set1_active;
  logic transfer;

  // Vblank moves sets to the active stage; a post divider write with the
  // oscillator off finalises them at once since no frame is running
  assign transfer = vblank || (post_write && !ctl_q[`POS_OSC_ON]);

  double_buffer_reg #(
    .WIDTH(32),
    .RESET_VALUE(`RST_DIV_SET0),
    .WRITE_MASK(`MASK_DIV_SET0)
  ) u_set0 (
    .clk(clk),
    .reset(reset),
    .write_en(reg_write && hit_set0 && !panel_connected),
    .write_data(reg_wdata),
    .transfer(transfer),
    .written_q(set0_written),
    .active_q(set0_active)
  );

  double_buffer_reg #(
    .WIDTH(32),
    .RESET_VALUE(`RST_DIV_SET1),
    .WRITE_MASK(`MASK_DIV_SET1)
  ) u_set1 (
    .clk(clk),
    .reset(reset),
    .write_en(reg_write && hit_set1 && !panel_connected),
    .write_data(reg_wdata),
    .transfer(transfer),
    .written_q(set1_written),
    .active_q(set1_active)
  );

  // ***************************************************
  // Read port
  // ***************************************************
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (hit_ctl) begin
      rdata_d = ctl_q;
    end else if (hit_set0) begin
      rdata_d = set0_written;
    end else if (hit_set1) begin
      rdata_d = set1_written;
    end else if (hit_ref) begin
      rdata_d = ref_q;
    end else if (hit_raw) begin
      rdata_d = raw_q;
    end else if (hit_mod) begin
      rdata_d = mod_q;
    end
  end

  // ***************************************************
  // Post divider decode
  // ***************************************************
  logic [3:0] ratio_d;
  logic reserved_d;
  logic [7:0] post_byte;

  assign post_byte = ctl_q[`ALT_POST_HI:`ALT_POST_LO];

  always_comb begin
    reserved_d = 1'b0;
    case (post_byte)
      8'h01: ratio_d = 4'h1;
      8'h02: ratio_d = 4'h2;
      8'h04: ratio_d = 4'h3;
      8'h08: ratio_d = 4'h4;
      8'h10: ratio_d = 4'h5;
      8'h20: ratio_d = 4'h6;
      8'h40: ratio_d = 4'h7;
      8'h80: ratio_d = 4'h8;
      default: begin
        ratio_d = 4'h0;
        reserved_d = 1'b1;
      end
    endcase
  end

  // ***************************************************
  // Modulator settle timer
  // ***************************************************
  // PLLs on a modulated reference must wait this long; the flag lets
  // the enable logic outside hold off rather than trusting software
  localparam logic [7:0] SETTLE_CYC = 8'(`MOD_SETTLE_CYC);
  settle_state_t settle_q, settle_d;
  logic [7:0] settle_cnt_q, settle_cnt_d;
  logic mod_any;

  assign mod_any = ref_q[`POS_HALF_MOD_ON] || ref_q[`POS_VAR_MOD_ON];

  always_comb begin
    settle_d = settle_q;
    settle_cnt_d = settle_cnt_q;
    case (settle_q)
      SETTLE_IDLE: begin
        settle_cnt_d = 8'h00;
        if (mod_any) begin
          settle_d = SETTLE_WAIT;
        end
      end
      SETTLE_WAIT: begin
        settle_cnt_d = settle_cnt_q + 8'h01;
        if (!mod_any) begin
          settle_d = SETTLE_IDLE;
        end else if (settle_cnt_q == SETTLE_CYC - 8'h02) begin
          settle_d = SETTLE_DONE;
        end
      end
      SETTLE_DONE: begin
        if (!mod_any) begin
          settle_d = SETTLE_IDLE;
        end
      end
      default: settle_d = SETTLE_IDLE;
    endcase
  end

  // ***************************************************
  // Timer tick from the raw clock divisor
  // ***************************************************
  logic [9:0] tick_cnt_q, tick_cnt_d;
  logic tick_d;

  always_comb begin
    tick_cnt_d = tick_cnt_q + 10'h001;
    tick_d = 1'b0;
    if (raw_q[`RAW_FREQ_HI:`RAW_FREQ_LO] == 10'h000) begin
      tick_cnt_d = 10'h000;
    end else if (tick_cnt_q >= raw_q[`RAW_FREQ_HI:`RAW_FREQ_LO] - 10'h001) begin
      tick_cnt_d = 10'h000;
      tick_d = 1'b1;
    end
  end

  // ***************************************************
  // Output decode
  // ***************************************************
  logic [31:0] act_set;
  logic osc_d;
  logic spread_d;
  logic flat_int_d;
  logic flat_ext_d;
  logic wide_d;
  logic half_d;
  logic var_d;

  assign act_set = alternate_in_use ? set1_active : set0_active;
  assign osc_d = ctl_q[`POS_OSC_ON];
  assign spread_d = ref_q[`SPREAD_SEL_HI:`SPREAD_SEL_LO] == 2'h2;
  assign flat_int_d = ref_q[`FLAT_SEL_HI:`FLAT_SEL_LO] == 2'h2;
  assign flat_ext_d = ref_q[`FLAT_SEL_HI:`FLAT_SEL_LO] == 2'h1;
  assign wide_d = ref_q[`WIDE_SEL_HI:`WIDE_SEL_LO] == 2'h2;
  assign half_d = ref_q[`POS_HALF_MOD_ON] && spread_d;
  // Without the wide source the variable modulator has no clock to shape
  assign var_d = ref_q[`POS_VAR_MOD_ON] && wide_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
      write_blocked <= 1'b0;
      pll_oscillator_on <= 1'b0;
      display_clock_run <= 1'b0;
      post_div_ratio <= 4'h8;
      post_div_reserved <= 1'b0;
      n_div <= 6'h00;
      m_coarse_div <= 6'h00;
      m_fine_div <= 6'h00;
      vco_band_tune <= 3'h0;
      doubler_clock_on <= 1'b0;
      spread_source_on <= 1'b0;
      flat_source_internal <= 1'b0;
      flat_source_external <= 1'b0;
      wide_spread_source_on <= 1'b0;
      cpu_ref_spread_out <= 1'b0;
      cpu_ref_flat_out <= 1'b0;
      half_pct_modulator_on <= 1'b0;
      variable_modulator_on <= 1'b0;
      variable_modulator_spread_type <= 1'b0;
      modulated_ref_stable <= 1'b0;
      long_mix_repeats <= 3'h1;
      timer_tick <= 1'b0;
      settle_q <= SETTLE_IDLE;
      settle_cnt_q <= 8'h00;
      tick_cnt_q <= 10'h000;
    end else begin
      reg_rdata <= reg_read ? rdata_d : 32'h00000000;
      reg_rvalid <= reg_read;
      write_blocked <= set_write && panel_connected;
      pll_oscillator_on <= osc_d;
      display_clock_run <= osc_d;
      post_div_ratio <= ratio_d;
      post_div_reserved <= reserved_d;
      // Divisors are handed on in register form, each two below its ratio
      n_div <= act_set[`N_DIV_HI:`N_DIV_LO];
      m_coarse_div <= act_set[`M_COARSE_HI:`M_COARSE_LO];
      m_fine_div <= act_set[`M_FINE_HI:`M_FINE_LO];
      vco_band_tune <= act_set[`BAND_TUNE_HI:`BAND_TUNE_LO];
      doubler_clock_on <= osc_d && set0_active[`POS_DOUBLER_ON];
      spread_source_on <= spread_d;
      flat_source_internal <= flat_int_d;
      flat_source_external <= flat_ext_d;
      wide_spread_source_on <= wide_d;
      cpu_ref_spread_out <= ref_q[`CPU_SEL_HI:`CPU_SEL_LO] == 2'h2 && spread_d && half_d;
      cpu_ref_flat_out <= ref_q[`CPU_SEL_HI:`CPU_SEL_LO] == 2'h3
        && (flat_int_d || flat_ext_d);
      half_pct_modulator_on <= half_d;
      variable_modulator_on <= var_d;
      variable_modulator_spread_type <= ref_q[`POS_SPREAD_TYPE];
      modulated_ref_stable <= settle_d == SETTLE_DONE;
      long_mix_repeats <= {1'b0, mod_q[`LONG_MIX_HI:`LONG_MIX_LO]} + 3'h1;
      timer_tick <= tick_d;
      settle_q <= settle_d;
      settle_cnt_q <= settle_cnt_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_post_one_hot: assert property (
    !post_div_reserved |-> post_div_ratio != 4'h0)
    else $error("post divider ratio zero without reserved flag");

  a_post_immediate: assert property (
    post_write && reg_wdata[7:0] == 8'h04 |-> ##2 post_div_ratio == 4'h3)
    else $error("post divider write did not apply at once");

  a_post_finalize: assert property (
    post_write && !ctl_q[`POS_OSC_ON] |=> set0_active == $past(set0_written))
    else $error("post divider write did not load divisors");

  a_set_held: assert property (
    !vblank && !post_write |=> $stable(set0_active) && $stable(set1_active))
    else $error("active divisor set changed outside update point");

  a_write_block: assert property (
    reg_write && hit_set0 && panel_connected |=> $stable(set0_written)
      ##0 write_blocked)
    else $error("divisor set written while panel connected");

  a_doubler_gate: assert property (
    !set0_active[`POS_DOUBLER_ON] |=> !doubler_clock_on)
    else $error("doubler clocked while disabled");

  a_spread_decode: assert property (
    ref_q[`SPREAD_SEL_HI:`SPREAD_SEL_LO] != 2'h2 |=> !spread_source_on)
    else $error("spread source on for non-enable code");

  a_wide_gate: assert property (
    !wide_d |=> !variable_modulator_on)
    else $error("variable modulator on without wide source");

  a_settle_wait: assert property (
    $rose(mod_any) |=> !modulated_ref_stable [*8])
    else $error("modulated reference flagged stable too early");

  a_settle_bound: assert property (
    $rose(mod_any) |-> ##[1:50] (modulated_ref_stable || !mod_any))
    else $error("modulated reference not stable after settle time");

  a_osc_off: assert property (
    !ctl_q[`POS_OSC_ON] |=> !display_clock_run && !pll_oscillator_on)
    else $error("display clock runs with oscillator off");

  a_reserved_zero: assert property (
    reg_rvalid |-> (reg_rdata & ~(`MASK_DIV_SET0 | `MASK_PLL_CONTROL
      | `MASK_MOD_PARAMS | `MASK_REF_CONTROL)) == 32'h00000000)
    else $error("reserved bits read as one");

  c_vblank_update: cover property (set_write && !panel_connected ##[1:20] vblank);
  c_post_finalize: cover property (post_write && !ctl_q[`POS_OSC_ON]);
  c_blocked: cover property (write_blocked);
  c_settled: cover property ($rose(modulated_ref_stable));

endmodule // display_pll_divisor_and_ref_clock_ctl

`default_nettype wire

// ---- verilog/double_buffer_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

module double_buffer_reg #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] WRITE_MASK = '1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic write_en,
  input wire logic [WIDTH-1:0] write_data,
  input wire logic transfer,
  output logic [WIDTH-1:0] written_q,
  output logic [WIDTH-1:0] active_q
);

  logic [WIDTH-1:0] written_d;
  logic [WIDTH-1:0] active_d;

  // Active stage takes the first stage as it stands before this cycle's write
  always_comb begin
    written_d = written_q;
    active_d = active_q;
    if (write_en) begin
      written_d = write_data & WRITE_MASK;
    end
    if (transfer) begin
      active_d = written_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      written_q <= RESET_VALUE;
      active_q <= RESET_VALUE;
    end else begin
      written_q <= written_d;
      active_q <= active_d;
    end
  end

endmodule // double_buffer_reg

`default_nettype wire

// ---- verilog/pll_ref_defines.svh ----
`ifndef PLL_REF_DEFINES_SVH
`define PLL_REF_DEFINES_SVH

// ***************************************************
// Register byte addresses
// ***************************************************
`define ADDR_PLL_CONTROL 20'hC6014
`define ADDR_DIV_SET0 20'hC6040
`define ADDR_DIV_SET1 20'hC6044
`define ADDR_REF_CONTROL 20'hC6200
`define ADDR_RAW_FREQ 20'hC6204
`define ADDR_MOD_PARAMS 20'hC6210

// ***************************************************
// Reset values and writable-bit masks
// ***************************************************
`define RST_PLL_CONTROL 32'h00000080
`define MASK_PLL_CONTROL 32'h800000FF
`define RST_DIV_SET0 32'h00030D07
`define MASK_DIV_SET0 32'h09FF3F3F
`define RST_DIV_SET1 32'h00030D07
`define MASK_DIV_SET1 32'h01FF3F3F
`define RST_REF_CONTROL 32'h00000000
`define MASK_REF_CONTROL 32'h00007FC3
`define RST_RAW_FREQ 32'h00000000
`define MASK_RAW_FREQ 32'h000003FF
`define RST_MOD_PARAMS 32'h01204860
`define MASK_MOD_PARAMS 32'h3777FFFF

// ***************************************************
// Field positions
// ***************************************************
`define POS_OSC_ON 31
`define POS_DOUBLER_ON 27
`define BAND_TUNE_HI 24
`define BAND_TUNE_LO 22
`define N_DIV_HI 21
`define N_DIV_LO 16
`define M_COARSE_HI 13
`define M_COARSE_LO 8
`define M_FINE_HI 5
`define M_FINE_LO 0
`define ALT_POST_HI 7
`define ALT_POST_LO 0
`define CPU_SEL_HI 14
`define CPU_SEL_LO 13
`define SPREAD_SEL_HI 12
`define SPREAD_SEL_LO 11
`define FLAT_SEL_HI 10
`define FLAT_SEL_LO 9
`define WIDE_SEL_HI 8
`define WIDE_SEL_LO 7
`define POS_SPREAD_TYPE 6
`define POS_HALF_MOD_ON 1
`define POS_VAR_MOD_ON 0
`define RAW_FREQ_HI 9
`define RAW_FREQ_LO 0
`define LONG_MIX_HI 29
`define LONG_MIX_LO 28

// ***************************************************
// Timing
// ***************************************************
`define CLK_PERIOD_NS 20
`define MOD_SETTLE_NS 1000
`define MOD_SETTLE_CYC ((`MOD_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- verilog/pll_ref_pkg.sv ----
`default_nettype none

package pll_ref_pkg;

  typedef logic [1:0] src_code_t;

  typedef enum {
    SETTLE_IDLE,
    SETTLE_WAIT,
    SETTLE_DONE
  } settle_state_t;

endpackage

`default_nettype wire
